// File: hpc_convert.sv
// single to half precision converter with exception handling, AXI4-Lite registers
// assumes one clock, a synchronous low reset and a well behaved bus master
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "hpc_regs.svh"

module hpc_convert
  import hpc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              aclk,    // core clock, 10 MHz
  input  wire logic              aresetn, // sync reset, low
  input  wire logic [ADDR_W-1:0] awaddr,  // write address
  input  wire logic [2:0]        awprot,  // unused protection
  input  wire logic              awvalid, // write address valid
  output logic                   awready, // write address ready
  input  wire logic [31:0]       wdata,   // write data
  input  wire logic [3:0]        wstrb,   // byte enables
  input  wire logic              wvalid,  // write data valid
  output logic                   wready,  // write data ready
  output logic [1:0]             bresp,   // write response
  output logic                   bvalid,  // write response valid
  input  wire logic              bready,  // write response ready
  input  wire logic [ADDR_W-1:0] araddr,  // read address
  input  wire logic [2:0]        arprot,  // unused protection
  input  wire logic              arvalid, // read address valid
  output logic                   arready, // read address ready
  output logic [31:0]            rdata,   // read data
  output logic [1:0]             rresp,   // read response
  output logic                   rvalid,  // read data valid
  input  wire logic              rready,  // read data ready
  output logic                   irq,     // level interrupt
  output logic                   fp_fault // one cycle fault pulse
);

  // ==========================================
  // elaboration checks and helpers
  if (ADDR_W < 8)
  begin : g_chk
    $error("hpc_convert needs ADDR_W of at least 8");
  end

  // word hit on byte address bits 7:2
  function automatic logic hpc_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hpc_hit = (a[7:2] == ofs[7:2]);
  endfunction

  // byte lane merge for writable registers
  function automatic logic [31:0] hpc_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
    hpc_merge = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        hpc_merge[8*i +: 8] = nw[8*i +: 8];
  endfunction

  // ==========================================
  // state
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              aw_full;
  logic              w_full;
  logic [15:0]       fcsr;
  logic [31:0]       src;
  logic [7:0]        imm;
  logic              go;
  logic [15:0]       res;
  logic              last_fault;
  logic [1:0]        istat;
  logic [1:0]        ien;

  // ==========================================
  // write channel decode
  wire aw_hs        = awvalid & awready;
  wire w_hs         = wvalid & wready;
  wire wr_do        = aw_full & w_full;
  wire next_aw_full = aw_full ? ~wr_do : aw_hs;
  wire next_w_full  = w_full ? ~wr_do : w_hs;
  wire next_bvalid  = wr_do | (bvalid & ~bready);
  wire wr_fcsr      = wr_do & hpc_hit(wr_addr, `HPC_FCSR_ADDR);
  wire wr_src       = wr_do & hpc_hit(wr_addr, `HPC_SRC_ADDR);
  wire wr_imm       = wr_do & hpc_hit(wr_addr, `HPC_IMM_ADDR);
  wire wr_cmd       = wr_do & hpc_hit(wr_addr, `HPC_CMD_ADDR);
  wire wr_iclr      = wr_do & hpc_hit(wr_addr, `HPC_ICLR_ADDR);
  wire wr_ien       = wr_do & hpc_hit(wr_addr, `HPC_IEN_ADDR);
  wire wr_ok        = wr_fcsr | wr_src | wr_imm | wr_cmd | wr_iclr | wr_ien
                    | hpc_hit(wr_addr, `HPC_RES_ADDR) | hpc_hit(wr_addr, `HPC_FEAT_ADDR)
                    | hpc_hit(wr_addr, `HPC_ISTAT_ADDR);
  wire [31:0] wr_merged = hpc_merge({16'h0000, fcsr}, wr_data, wr_strb);
  wire [31:0] src_merged = hpc_merge(src, wr_data, wr_strb);
  wire [31:0] imm_merged = hpc_merge({24'h000000, imm}, wr_data, wr_strb);
  wire [31:0] ien_merged = hpc_merge({30'h0, ien}, wr_data, wr_strb);

  // ==========================================
  // conversion datapath
  // rounding selection from immediate or status field
  // rounding mode select
  wire [1:0]  rsel    = imm[`HPC_IMM_MS] ? fcsr[`HPC_RC_LSB +: 2] : imm[1:0];
  hpc_round_t rmode;
  assign rmode = hpc_round_t'(rsel);
  wire        cv_sign = src[31];
  wire [7:0]  cv_exp  = src[30:23];
  wire [22:0] cv_frac = src[22:0];
  wire        cv_fin  = (cv_exp != 8'hFF);
  wire        cv_nan  = ~cv_fin & (cv_frac != 23'h0);
  wire        cv_inf  = ~cv_fin & (cv_frac == 23'h0);
  wire        cv_snan = cv_nan & ~cv_frac[22];
  wire        cv_dsrc = (cv_exp == 8'h00) & (cv_frac != 23'h0);
  wire [23:0] cv_sig  = {cv_exp != 8'h00, cv_frac};
  wire        cv_norm = (cv_exp >= 8'd113);
  // shift past the half format; capped so a denormal source leaves only sticky
  wire [7:0]  cv_drop = cv_norm ? 8'd13 : ((cv_exp <= 8'd101) ? 8'd25 : 8'd126 - cv_exp);
  wire [49:0] cv_ext  = {cv_sig, 26'h0} >> cv_drop;
  wire [10:0] cv_keep = cv_ext[36:26];
  wire        cv_grd  = cv_ext[25];
  wire        cv_stk  = |cv_ext[24:0];
  wire        cv_lost = cv_grd | cv_stk;
  wire        cv_inc  = (rmode == hpc_rnd_near) ? cv_grd & (cv_stk | cv_keep[0]) :
                        (rmode == hpc_rnd_down) ? cv_sign & cv_lost :
                        (rmode == hpc_rnd_up)   ? ~cv_sign & cv_lost : 1'b0;
  wire [7:0]  cv_base = cv_norm ? cv_exp - 8'd113 : 8'h00;
  // rounding carry ripples into the exponent on its own
  wire [18:0] cv_mag  = {1'b0, cv_base, 10'h000} + {8'h00, cv_keep} + {18'h0, cv_inc};
  wire        cv_of   = cv_fin & (cv_mag >= `HPC_HALF_INF);
  wire        cv_uf   = cv_fin & (cv_sig != 24'h0) & (cv_mag < `HPC_HALF_MINN);
  wire        cv_pe   = cv_fin & (cv_lost | cv_of);
  wire [15:0] cv_qnan = {cv_sign, `HPC_NAN_EXP, cv_frac[22] | cv_snan,
                         cv_frac[21:13]};
  wire [15:0] cv_res  = cv_nan ? cv_qnan :
                        (cv_inf | cv_of) ? {cv_sign, 15'(`HPC_HALF_INF)} : {cv_sign, cv_mag[14:0]};

  // ==========================================
  // exception raise and fault decision
  wire r_ie = cv_snan;
  wire r_de = cv_dsrc;
  wire r_oe = cv_of;
  // underflow raised; denormal source also raises underflow and precision
  wire r_ue = cv_uf | cv_dsrc;
  wire r_pe = cv_pe | cv_dsrc;
  wire m_ie = fcsr[`HPC_F_IE + `HPC_MASK_OFS];
  wire m_de = fcsr[`HPC_F_DE + `HPC_MASK_OFS];
  wire m_oe = fcsr[`HPC_F_OE + `HPC_MASK_OFS];
  wire m_ue = fcsr[`HPC_F_UE + `HPC_MASK_OFS];
  wire m_pe = fcsr[`HPC_F_PE + `HPC_MASK_OFS];
  wire hard_trap = (r_ie & ~m_ie) | (r_de & ~m_de) | (r_oe & ~m_oe) | (r_ue & ~m_ue);
  wire pe_trap   = r_pe & ~m_pe & ~((r_oe & m_oe) | (r_ue & m_ue));
  wire dn_trap   = r_de & m_de & (~m_pe | ~m_ue);
  wire fault_c   = hard_trap | pe_trap | dn_trap;
  logic [15:0] raise;

  // flag vector in status layout
  always_comb
  begin
    raise = 16'h0000;
    raise[`HPC_F_IE] = r_ie;
    raise[`HPC_F_DE] = r_de;
    raise[`HPC_F_OE] = r_oe;
    raise[`HPC_F_UE] = r_ue;
    raise[`HPC_F_PE] = r_pe;
  end

  // raised flags win over a software write
  wire [15:0] next_fcsr  = (wr_fcsr ? wr_merged[15:0] : fcsr) | (go ? raise : 16'h0000);
  // interrupt events; a new event wins over the clear
  wire [1:0]  ev         = go ? {fault_c, ~fault_c} : 2'b00;
  wire [1:0]  next_istat = (istat & ~(wr_iclr ? wr_data[1:0] & {2{wr_strb[0]}} : 2'b00)) | ev;
  wire [1:0]  next_ien   = wr_ien ? ien_merged[1:0] : ien;

  // ==========================================
  // read decode
  wire ar_hs       = arvalid & arready;
  wire next_rvalid = ar_hs | (rvalid & ~rready);
  wire [31:0] feat = (32'h1 << `HPC_FEAT_VEC) | (32'h1 << `HPC_FEAT_HALF);
  wire rd_fcsr = hpc_hit(araddr, `HPC_FCSR_ADDR);
  wire rd_src  = hpc_hit(araddr, `HPC_SRC_ADDR);
  wire rd_imm  = hpc_hit(araddr, `HPC_IMM_ADDR);
  wire rd_res  = hpc_hit(araddr, `HPC_RES_ADDR);
  wire rd_feat = hpc_hit(araddr, `HPC_FEAT_ADDR);
  wire rd_ist  = hpc_hit(araddr, `HPC_ISTAT_ADDR);
  wire rd_ien  = hpc_hit(araddr, `HPC_IEN_ADDR);
  // write-only registers read as zero but are mapped
  wire rd_wo   = hpc_hit(araddr, `HPC_CMD_ADDR) | hpc_hit(araddr, `HPC_ICLR_ADDR);
  wire rd_ok   = rd_fcsr | rd_src | rd_imm | rd_res | rd_feat | rd_ist | rd_ien | rd_wo;
  wire [31:0] rd_val = rd_fcsr ? {16'h0000, fcsr} :
                       rd_src  ? src :
                       rd_imm  ? {24'h000000, imm} :
                       rd_res  ? {15'h0000, last_fault, res} :
                       rd_feat ? feat :
                       rd_ist  ? {30'h0, istat} :
                       rd_ien  ? {30'h0, ien} : 32'h0000_0000;

  // ==========================================
  // write channel registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `HPC_RESP_OK;
    end
    else
    begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      awready <= ~next_aw_full & ~next_bvalid;
      wready  <= ~next_w_full & ~next_bvalid;
      bvalid  <= next_bvalid;
      if (wr_do)
        bresp <= wr_ok ? `HPC_RESP_OK : `HPC_RESP_ERR;
    end
  end

  // captured write payload, no reset needed for data
  always_ff @(posedge aclk)
  begin
    if (aw_hs)
      wr_addr <= awaddr;
    if (w_hs)
    begin
      wr_data <= wdata;
      wr_strb <= wstrb;
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `HPC_RESP_OK;
    end
    else
    begin
      arready <= ~next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_hs)
      begin
        rdata <= rd_val;
        rresp <= rd_ok ? `HPC_RESP_OK : `HPC_RESP_ERR;
      end
    end
  end

  // flush bit stored, never read by the datapath
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fcsr <= `HPC_FCSR_RST;
      src  <= 32'h0000_0000;
      imm  <= 8'h00;
      ien  <= 2'b00;
    end
    else
    begin
      fcsr <= next_fcsr;
      ien  <= next_ien;
      if (wr_src)
        src <= src_merged;
      if (wr_imm)
        imm <= imm_merged[7:0];
    end
  end

  // conversion launch and commit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      go         <= 1'b0;
      res        <= 16'h0000;
      last_fault <= 1'b0;
      fp_fault   <= 1'b0;
    end
    else
    begin
      go       <= wr_cmd & wr_strb[0] & wr_data[0];
      fp_fault <= go & fault_c;
      if (go)
        last_fault <= fault_c;
      if (go & ~fault_c)
        res <= cv_res;
    end
  end

  // interrupt status and output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      istat <= 2'b00;
      irq   <= 1'b0;
    end
    else
    begin
      istat <= next_istat;
      irq   <= |(next_istat & next_ien);
    end
  end

  // ==========================================
  // assertions
  underflow_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    go && r_ue |=> fcsr[`HPC_F_UE]) else $error("underflow flag not set");
  tiny_detect_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cv_fin && cv_exp < 8'd112 && cv_sig != 24'h0 |-> cv_uf)
    else $error("tiny result not flagged");
  no_flush_a: assert property (@(posedge aclk) disable iff (!aresetn)
    go && !fault_c && cv_uf && cv_mag != 19'h0 |=> res[14:0] != 15'h0)
    else $error("tiny result flushed");
  overflow_inf_a: assert property (@(posedge aclk) disable iff (!aresetn)
    go && cv_fin && cv_mag >= `HPC_HALF_INF && !fault_c |=> res[14:0] == 15'h7C00
    && fcsr[`HPC_F_OE]) else $error("overflow result wrong");
  nan_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    go && cv_nan && !fault_c |=> res[14:10] == 5'h1F && res[9])
    else $error("NaN not quieted");
  denorm_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    go && cv_dsrc |=> fcsr[`HPC_F_DE] && fcsr[`HPC_F_UE] && fcsr[`HPC_F_PE])
    else $error("denormal flags missing");
  fault_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    go && fault_c |=> $stable(res) && fp_fault) else $error("faulting result written");
  sticky_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fcsr[`HPC_F_PE] && !wr_fcsr |=> fcsr[`HPC_F_PE]) else $error("sticky flag dropped");
  feature_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && rd_feat |=> rdata[29:28] == 2'b11) else $error("feature bits wrong");
  round_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !imm[2] && imm[1:0] == 2'b11 |-> !cv_inc) else $error("rounding override ignored");

endmodule

// File: hpc_regs.svh
// register offsets, field positions, reset values and constants
// assumes a 32-bit register bus decoded on byte address bits 7:2
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH
// ==========================================
// register byte offsets
`define HPC_FCSR_ADDR  8'h00
`define HPC_SRC_ADDR   8'h04
`define HPC_IMM_ADDR   8'h08
`define HPC_CMD_ADDR   8'h0C
`define HPC_RES_ADDR   8'h10
`define HPC_FEAT_ADDR  8'h14
`define HPC_ISTAT_ADDR 8'h18
`define HPC_ICLR_ADDR  8'h1C
`define HPC_IEN_ADDR   8'h20
// ==========================================
// fp control/status fields (mask bit = flag bit + mask offset)
`define HPC_F_IE       0
`define HPC_F_DE       1
`define HPC_F_OE       3
`define HPC_F_UE       4
`define HPC_F_PE       5
`define HPC_MASK_OFS   7
`define HPC_RC_LSB     13
`define HPC_FTZ_BIT    15
`define HPC_FCSR_RST   16'h1F80
// ==========================================
// other fields and constants
`define HPC_IMM_MS     2
`define HPC_FEAT_VEC   28
`define HPC_FEAT_HALF  29
`define HPC_EV_DONE    0
`define HPC_EV_FAULT   1
`define HPC_HALF_INF   19'h07C00
`define HPC_HALF_MINN  19'h00400
`define HPC_NAN_EXP    5'h1F
`define HPC_RESP_OK    2'h0
`define HPC_RESP_ERR   2'h2
`endif

// File: hpc_pkg.sv
// types shared by the half precision converter
// assumes nothing beyond the standard language
package hpc_pkg;
  // rounding selections, in immediate field order
  typedef enum logic [1:0] {hpc_rnd_near, hpc_rnd_down, hpc_rnd_up, hpc_rnd_trunc} hpc_round_t;
endpackage

// File: hpc_sw_gate.sv
// software side model: decides whether conversions may be issued
// assumes the feature word is fed from a bus read of the block
`timescale 1ns/100ps
module hpc_sw_gate
#(
  parameter logic [31:0] STATE_EN = 32'h0000_0007, // control zero as the os grants it
  parameter logic        OS_SAVE  = 1'b1           // os save enabled flag
)
(
  input  wire logic [31:0] feat,    // feature word read from the block
  output logic             may_run  // every check passed
);
  logic [31:0] leaf_one; // identification word as software sees it
  logic        feat_ok;  // three feature flags present
  logic        state_ok; // both register states enabled
  // ======
  // checks
  // the os flag lives outside the block, so the model adds it
  assign leaf_one = feat | {4'h0, OS_SAVE, 27'h0000000};
  assign feat_ok  = (leaf_one & 32'h3800_0000) == 32'h3800_0000;
  assign state_ok = (STATE_EN & 32'h0000_0006) == 32'h0000_0006;
  assign may_run  = feat_ok & state_ok;
endmodule

// File: test_half_precision_convert_exceptions.sv
// self-checking bench for the half precision converter
// assumes hpc_convert and hpc_sw_gate are compiled before it
`timescale 1ns/100ps
`include "hpc_regs.svh"
module test_half_precision_convert_exceptions;
  logic        aclk      = 1'b0;
  logic        aresetn   = 1'b0;
  logic [7:0]  awaddr    = 8'h00;
  logic [7:0]  araddr    = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic        awvalid   = 1'b0;
  logic        wvalid    = 1'b0;
  logic        arvalid   = 1'b0;
  logic        bready    = 1'b0;
  logic        rready    = 1'b0;
  logic [3:0]  wstrb     = 4'hF;
  logic        awready, wready, arready, bvalid, rvalid, irq, fp_fault, may_run;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] feat_word = 32'h0;
  logic [15:0] lfsr      = 16'h8BF5; // seed 35829
  logic [15:0] last_res  = 16'h0000; // result kept across faults
  int          failures  = 0;
  int          checks    = 0;
  int          cycles    = 0;
  int          fault_cyc = 0;

  always #50 aclk = ~aclk;

  hpc_convert #(.ADDR_W(8)) hpc_convert_inst
  (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq), .fp_fault(fp_fault)
  );
  hpc_sw_gate hpc_sw_gate_inst
  (
    .feat(feat_word), .may_run(may_run)
  );

  // ======
  // fault pulse width and watchdog; a hang counts as a mismatch
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (fp_fault === 1'b1)
      fault_cyc <= fault_cyc + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      give_verdict();
    end
  end

  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // exact widening, so the narrowing must give back the same half
  function automatic logic [31:0] half_to_single(input logic [15:0] h);
    return {h[15], 8'(h[14:10]) + 8'h70, h[9:0], 13'h0000};
  endfunction

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_bit(input string what, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask
  // response ready rises with the request and drops at the edge that takes the answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic settle();
    @(posedge aclk);
    @(negedge aclk);
  endtask
  // one conversion: flags cleared by the control write, result and flags read back
  task automatic cv(input logic [15:0] cfg, input logic [7:0] im, input logic [31:0] s,
                    input logic [15:0] er, input logic [7:0] ef, input logic flt = 1'b0,
                    input logic [7:0] ec = 8'h3B);
    logic [31:0] d;
    logic [1:0]  r;
    int          f0;
    f0 = fault_cyc;
    axi_wr(`HPC_FCSR_ADDR, {16'h0000, cfg}, r);
    axi_wr(`HPC_SRC_ADDR, s, r);
    axi_wr(`HPC_IMM_ADDR, {24'h000000, im}, r);
    axi_wr(`HPC_CMD_ADDR, 32'h0000_0001, r);
    axi_rd(`HPC_RES_ADDR, d, r);
    if (!flt)
      last_res = er;
    chk_word("result", {15'h0000, flt, last_res}, d);
    axi_rd(`HPC_FCSR_ADDR, d, r);
    chk_word("flags", {24'h000000, ef & ec}, {24'h000000, d[7:0] & ec});
    chk_word("fault cycles", {31'h0, flt}, 32'(fault_cyc - f0));
  endtask

  // ======
  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] h;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`HPC_FCSR_ADDR, d, r);
    chk_word("fcsr reset", 32'h0000_1F80, d);
    axi_rd(`HPC_FEAT_ADDR, d, r);
    chk_word("feature word", 32'h3000_0000, d);
    feat_word = d;
    axi_wr(`HPC_RES_ADDR, 32'hFFFF_FFFF, r);
    axi_rd(`HPC_RES_ADDR, d, r);
    chk_word("result read only", 32'h0, d);
    axi_rd(8'h40, d, r);
    chk_word("unmapped read", 32'h2, {30'h0, r});
    axi_wr(8'h44, 32'h0, r);
    chk_word("unmapped write", 32'h2, {30'h0, r});
    wstrb <= 4'h1;
    axi_wr(`HPC_SRC_ADDR, 32'hFFFF_FFFF, r);
    wstrb <= 4'hF;
    axi_rd(`HPC_SRC_ADDR, d, r);
    chk_word("byte lane write", 32'h0000_00FF, d);
    chk_bit("software gate", 1'b1, may_run);
    $display("test registers done");
    cv(16'h1F80, 8'h00, 32'h3F80_0000, 16'h3C00, 8'h00);
    cv(16'h1F80, 8'h00, 32'h477F_E000, 16'h7BFF, 8'h00);
    cv(16'h1F80, 8'h00, 32'h4780_0000, 16'h7C00, 8'h08, 1'b0, 8'h1B);
    cv(16'h1F80, 8'h00, 32'hC780_0000, 16'hFC00, 8'h08, 1'b0, 8'h1B);
    cv(16'h1F80, 8'h00, 32'h3880_0000, 16'h0400, 8'h00);
    cv(16'h1F80, 8'h00, 32'h3800_0000, 16'h0200, 8'h10);
    cv(16'h9F80, 8'h00, 32'h3800_0000, 16'h0200, 8'h10);
    cv(16'h1F80, 8'h00, 32'h3F80_0001, 16'h3C00, 8'h20);
    cv(16'h1F80, 8'h02, 32'h3F80_0001, 16'h3C01, 8'h20);
    cv(16'h1F80, 8'h01, 32'hBF80_0001, 16'hBC01, 8'h20);
    cv(16'h1F80, 8'h03, 32'hBF80_0001, 16'hBC00, 8'h20);
    cv(16'h5F80, 8'h04, 32'h3F80_0001, 16'h3C01, 8'h20);
    cv(16'h1F80, 8'hFA, 32'h3F80_0001, 16'h3C01, 8'h20);
    cv(16'h1F80, 8'h00, 32'h7FC0_0000, 16'h7E00, 8'h00);
    cv(16'h1F80, 8'h00, 32'hFFA0_0000, 16'hFF00, 8'h01);
    cv(16'h1F80, 8'h00, 32'h0000_0001, 16'h0000, 8'h02, 1'b0, 8'h02);
    cv(16'h0F80, 8'h00, 32'h0000_0001, 16'h0000, 8'h32, 1'b1, 8'h32);
    cv(16'h1B80, 8'h00, 32'h4780_0000, 16'h0000, 8'h08, 1'b1, 8'h08);
    cv(16'h0F80, 8'h00, 32'h4780_0000, 16'h7C00, 8'h08, 1'b0, 8'h08);
    cv(16'h1780, 8'h00, 32'h3800_0001, 16'h0000, 8'h10, 1'b1, 8'h10);
    $display("test exceptions done");
    for (int i = 0; i < 24; i++)
    begin
      lfsr = next_rand(lfsr);
      h = lfsr;
      if (h[14:10] == 5'h00 || h[14:10] == 5'h1F)
        h[14:10] = 5'h0F;
      lfsr = next_rand(lfsr);
      cv(16'h1F80 | (lfsr & 16'hE000), lfsr[7:0], half_to_single(h), h, 8'h00);
    end
    $display("test random exact values done");
    axi_wr(`HPC_FCSR_ADDR, 32'h0000_1F80, r);
    axi_wr(`HPC_SRC_ADDR, 32'h3F80_0001, r);
    axi_wr(`HPC_CMD_ADDR, 32'h0000_0001, r);
    axi_wr(`HPC_SRC_ADDR, 32'h3800_0000, r);
    axi_wr(`HPC_CMD_ADDR, 32'h0000_0001, r);
    axi_rd(`HPC_FCSR_ADDR, d, r);
    chk_word("sticky flags", 32'h30, {24'h0, d[7:0] & 8'h3B});
    $display("test sticky flags done");
    axi_wr(`HPC_ICLR_ADDR, 32'h3, r);
    axi_wr(`HPC_IEN_ADDR, 32'h1, r);
    cv(16'h1F80, 8'h00, 32'h3F80_0000, 16'h3C00, 8'h00);
    axi_rd(`HPC_ISTAT_ADDR, d, r);
    chk_word("done status", 32'h1, d);
    settle();
    chk_bit("irq on", 1'b1, irq);
    axi_wr(`HPC_IEN_ADDR, 32'h0, r);
    settle();
    chk_bit("irq masked", 1'b0, irq);
    axi_wr(`HPC_IEN_ADDR, 32'h2, r);
    cv(16'h1B80, 8'h00, 32'h4780_0000, 16'h0000, 8'h08, 1'b1, 8'h08);
    settle();
    chk_bit("irq fault", 1'b1, irq);
    axi_wr(`HPC_ICLR_ADDR, 32'h2, r);
    settle();
    chk_bit("irq cleared", 1'b0, irq);
    $display("test interrupts done");
    give_verdict();
  end
endmodule
